// *** rtl/sawt_pkg.sv ***
`default_nettype none
package sawt_pkg;
    // register byte offsets on the bus
    localparam logic [3:0]  OFS_AREA5         = 4'h0;
    localparam logic [3:0]  OFS_AREA6         = 4'h4;
    localparam logic [3:0]  OFS_CFG           = 4'h8;
    localparam logic [3:0]  OFS_STAT          = 4'hC;
    // values after reset: wait code 1010 in bits 10:7
    localparam logic [31:0] AREA5_RST         = 32'h0000_0500;
    localparam logic [31:0] AREA6_RST         = 32'h0000_0500;
    localparam logic [31:0] CFG_RST           = 32'h0000_0000;
    // writable bits, everything else reads zero
    localparam logic [31:0] AREA5_MASK        = 32'h0000_07C3;
    localparam logic [31:0] AREA6_MASK        = 32'h0010_1FC3;
    localparam logic [31:0] CFG_MASK          = 32'h0000_0001;
    // field positions
    localparam int          POS_WAIT          = 7;
    localparam int          POS_WM            = 6;
    localparam int          POS_HOLD          = 0;
    localparam int          POS_SETUP         = 11;
    localparam int          POS_BAS           = 20;
    localparam int          POS_BSRAM         = 0;
    localparam logic [3:0]  WAIT_CODE_RST     = 4'hA;
    // external port widths
    localparam int          ADDR_W            = 20;
    localparam int          DATA_W            = 16;
    // timing: one mclk is one half bus cycle
    localparam int          CLK_PERIOD_NS     = 25;
    localparam int          HALF_PER_CYC      = 2;
    localparam int          STROBE_BASE_CYC   = 1;
    localparam logic [4:0]  WAIT_CYC_MAX      = 5'h12;
    typedef enum logic [2:0] {
        ST_IDLE, ST_SETUP, ST_STROBE, ST_EXTWAIT, ST_HOLD
    } sawt_state_type;
endpackage : sawt_pkg
`default_nettype wire

// *** rtl/sawt_wait_decode.sv ***
`default_nettype none
module sawt_wait_decode
    import sawt_pkg::*;
(
    input  wire logic [3:0] code,
    output logic      [4:0] cycles
);
    // reserved codes fall back to the longest wait, the safest guess
    always_comb begin
        case (code)
            4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6: begin
                cycles = {1'b0, code};
            end
            4'h7: cycles = 5'h08;
            4'h8: cycles = 5'h0A;
            4'h9: cycles = 5'h0C;
            4'hA: cycles = 5'h0E;
            4'hB: cycles = 5'h12;
            default: cycles = WAIT_CYC_MAX;
        endcase
    end
endmodule : sawt_wait_decode
`default_nettype wire

// *** rtl/sawt_sram_area_wait_timing.sv ***
// What this block does
// - area 5 inserts wait cycles from a 4-bit code: 0..6, 8, 10, 12, 14, 18.
// - area 6 uses the same wait code for both reads and writes.
// - mask bit 0 honours the external wait input, 1 ignores it.
// - the wait mask applies even with zero programmed wait cycles.
// - address and select stay 0.5/1.5/2.5/3.5 cycles after strobes negate.
// - area 6 strobes assert 0.5/1.5/2.5/3.5 cycles after address and select.
// - byte SRAM, select clear: lane strobe pulses, direction held during writes.
// - byte SRAM, select set: lane strobe held whole access, direction pulses.
// - reserved register bits read zero; software writes them as zero.
// - wait field resets to 1010, giving 14 wait cycles.
`default_nettype none
module sawt_sram_area_wait_timing
    import sawt_pkg::*;
(
    input  wire logic              mclk,
    input  wire logic              srst,
    input  wire logic              hsel,
    input  wire logic [31:0]       haddr,
    input  wire logic [1:0]        htrans,
    input  wire logic              hwrite,
    input  wire logic [2:0]        hsize,
    input  wire logic [31:0]       hwdata,
    input  wire logic              hready,
    output logic      [31:0]       hrdata,
    output logic                   hreadyout,
    output logic                   hresp,
    input  wire logic              acc_req,
    input  wire logic              acc_area6,
    input  wire logic              acc_write,
    input  wire logic [ADDR_W-1:0] acc_addr,
    input  wire logic [DATA_W-1:0] acc_wdata,
    input  wire logic [1:0]        acc_be,
    output logic                   acc_busy,
    output logic                   acc_done,
    output logic      [DATA_W-1:0] acc_rdata,
    output logic      [ADDR_W-1:0] ext_addr,
    output logic      [1:0]        chip_select_n,
    output logic                   rd_n,
    output logic      [1:0]        byte_lane_strobe_n,
    output logic                   rd_wr_n,
    output logic      [DATA_W-1:0] ext_data_out,
    output logic                   ext_data_oe,
    input  wire logic [DATA_W-1:0] ext_data_in,
    input  wire logic              ext_wait_n
);
    logic [31:0]       area5_ff, nxt_area5;
    logic [31:0]       area6_ff, nxt_area6;
    logic [31:0]       cfg_ff, nxt_cfg;
    logic              wr_pend_ff;
    logic [3:0]        wr_ofs_ff;
    logic              addr_take;
    logic [31:0]       rd_mux;
    sawt_state_type    state_ff, nxt_state;
    logic [5:0]        cnt_ff, nxt_cnt;
    logic              area6_ff_q, nxt_area6_q;
    logic              write_ff, nxt_write;
    logic [1:0]        be_ff, nxt_be;
    logic              wm_ff, nxt_wm;
    logic              bas_ff, nxt_bas;
    logic              bsram_ff, nxt_bsram;
    logic [1:0]        hold_ff, nxt_hold;
    logic [1:0]        setup_ff, nxt_setup;
    logic [3:0]        wcode_ff, nxt_wcode;
    logic [4:0]        wait_cyc;
    logic [2:0]        wsync_ff;
    logic              wait_act_ff;
    logic              accept;
    logic              cs_act, strb_act;
    logic              strobe_ff;
    logic [5:0]        setup_half, strobe_half, hold_half;

    // bus slave: zero wait states, always OKAY
    assign addr_take = hsel && hready && htrans[1];
    always_comb begin
        nxt_area5 = area5_ff;
        nxt_area6 = area6_ff;
        nxt_cfg   = cfg_ff;
        if (wr_pend_ff) begin
            case (wr_ofs_ff)
                OFS_AREA5: nxt_area5 = hwdata & AREA5_MASK;
                OFS_AREA6: nxt_area6 = hwdata & AREA6_MASK;
                OFS_CFG:   nxt_cfg   = hwdata & CFG_MASK;
                default:   nxt_cfg   = cfg_ff;
            endcase
        end
    end

    // reads see the next values so a read right after a write returns it
    always_comb begin
        case ({|haddr[31:4], haddr[3:0]})
            {1'b0, OFS_AREA5}: rd_mux = nxt_area5;
            {1'b0, OFS_AREA6}: rd_mux = nxt_area6;
            {1'b0, OFS_CFG}:   rd_mux = nxt_cfg;
            {1'b0, OFS_STAT}:  rd_mux = {29'h0, wait_act_ff, strobe_ff, acc_busy};
            default:   rd_mux = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            area5_ff <= AREA5_RST;
            area6_ff <= AREA6_RST;
            cfg_ff   <= CFG_RST;
        end else begin
            area5_ff <= nxt_area5;
            area6_ff <= nxt_area6;
            cfg_ff   <= nxt_cfg;
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            wr_pend_ff <= 1'b0;
            wr_ofs_ff  <= 4'h0;
            hrdata     <= 32'h0000_0000;
            hreadyout  <= 1'b1;
            hresp      <= 1'b0;
        end else begin
            wr_pend_ff <= addr_take && hwrite && !(|haddr[31:4]);
            if (addr_take) begin
                wr_ofs_ff <= haddr[3:0];
            end
            if (addr_take && !hwrite) begin
                hrdata <= rd_mux;
            end
        end
    end

    // external wait input: three stages, a change counts when two agree
    always_ff @(posedge mclk) begin
        if (srst) begin
            wsync_ff    <= 3'b111;
            wait_act_ff <= 1'b0;
        end else begin
            wsync_ff <= {wsync_ff[1:0], ext_wait_n};
            if (wsync_ff[1] == wsync_ff[2]) begin
                wait_act_ff <= !wsync_ff[2];
            end
        end
    end
    // per-access settings, frozen at accept so mid-access writes do no harm
    assign accept = (state_ff == ST_IDLE) && acc_req;
    always_comb begin
        nxt_area6_q = area6_ff_q;
        nxt_write   = write_ff;
        nxt_be      = be_ff;
        nxt_wm      = wm_ff;
        nxt_bas     = bas_ff;
        nxt_bsram   = bsram_ff;
        nxt_hold    = hold_ff;
        nxt_setup   = setup_ff;
        nxt_wcode   = wcode_ff;
        if (accept) begin
            nxt_area6_q = acc_area6;
            nxt_write   = acc_write;
            nxt_be      = acc_be;
            if (acc_area6) begin
                nxt_wm    = area6_ff[POS_WM];
                nxt_hold  = area6_ff[POS_HOLD +: 2];
                nxt_setup = area6_ff[POS_SETUP +: 2];
                nxt_wcode = area6_ff[POS_WAIT +: 4];
                nxt_bas   = area6_ff[POS_BAS];
                nxt_bsram = cfg_ff[POS_BSRAM];
            end else begin
                nxt_wm    = area5_ff[POS_WM];
                nxt_hold  = area5_ff[POS_HOLD +: 2];
                nxt_setup = 2'b00;
                nxt_wcode = area5_ff[POS_WAIT +: 4];
                nxt_bas   = 1'b0;
                nxt_bsram = 1'b0;
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            area6_ff_q <= 1'b0;
            write_ff   <= 1'b0;
            be_ff      <= 2'b00;
            wm_ff      <= 1'b0;
            bas_ff     <= 1'b0;
            bsram_ff   <= 1'b0;
            hold_ff    <= 2'b00;
            setup_ff   <= 2'b00;
            wcode_ff   <= WAIT_CODE_RST;
        end else begin
            area6_ff_q <= nxt_area6_q;
            write_ff   <= nxt_write;
            be_ff      <= nxt_be;
            wm_ff      <= nxt_wm;
            bas_ff     <= nxt_bas;
            bsram_ff   <= nxt_bsram;
            hold_ff    <= nxt_hold;
            setup_ff   <= nxt_setup;
            wcode_ff   <= nxt_wcode;
        end
    end
    sawt_wait_decode u_wait_decode (
        .code   (nxt_wcode),
        .cycles (wait_cyc)
    );
    // counts in half cycles: one mclk is half a bus cycle
    assign setup_half  = 6'({nxt_setup, 1'b1});
    assign hold_half   = 6'({hold_ff, 1'b1});
    assign strobe_half = 6'((int'(wait_cyc) + STROBE_BASE_CYC) * HALF_PER_CYC);
    always_comb begin
        nxt_state = state_ff;
        nxt_cnt   = cnt_ff;
        case (state_ff)
            ST_IDLE: begin
                if (accept) begin
                    nxt_state = ST_SETUP;
                    nxt_cnt   = setup_half - 6'h01;
                end
            end
            ST_SETUP: begin
                if (cnt_ff == 6'h00) begin
                    nxt_state = ST_STROBE;
                    nxt_cnt   = strobe_half - 6'h01;
                end else begin
                    nxt_cnt = cnt_ff - 6'h01;
                end
            end
            ST_STROBE: begin
                if (cnt_ff != 6'h00) begin
                    nxt_cnt = cnt_ff - 6'h01;
                end else if (!wm_ff && wait_act_ff) begin
                    nxt_state = ST_EXTWAIT;
                end else begin
                    nxt_state = ST_HOLD;
                    nxt_cnt   = hold_half - 6'h01;
                end
            end
            ST_EXTWAIT: begin
                if (!wait_act_ff) begin
                    nxt_state = ST_HOLD;
                    nxt_cnt   = hold_half - 6'h01;
                end
            end
            ST_HOLD: begin
                if (cnt_ff == 6'h00) begin
                    nxt_state = ST_IDLE;
                end else begin
                    nxt_cnt = cnt_ff - 6'h01;
                end
            end
            default: begin
                nxt_state = ST_IDLE;
                nxt_cnt   = 6'h00;
            end
        endcase
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            state_ff <= ST_IDLE;
            cnt_ff   <= 6'h00;
        end else begin
            state_ff <= nxt_state;
            cnt_ff   <= nxt_cnt;
        end
    end
    assign cs_act   = (nxt_state != ST_IDLE);
    assign strb_act = (nxt_state == ST_STROBE) || (nxt_state == ST_EXTWAIT);
    // pin outputs registered from the next state, so no decode glitches
    always_ff @(posedge mclk) begin
        if (srst) begin
            strobe_ff          <= 1'b0;
            chip_select_n      <= 2'b11;
            rd_n               <= 1'b1;
            byte_lane_strobe_n <= 2'b11;
            rd_wr_n            <= 1'b1;
            ext_data_oe        <= 1'b0;
        end else begin
            strobe_ff        <= strb_act;
            chip_select_n[0] <= !(cs_act && !nxt_area6_q);
            chip_select_n[1] <= !(cs_act && nxt_area6_q);
            rd_n             <= !(strb_act && !nxt_write);
            ext_data_oe      <= cs_act && nxt_write;
            if (nxt_bsram && nxt_bas) begin
                byte_lane_strobe_n <= cs_act ? ~nxt_be : 2'b11;
                rd_wr_n            <= !(strb_act && nxt_write);
            end else if (nxt_bsram) begin
                byte_lane_strobe_n <= strb_act ? ~nxt_be : 2'b11;
                rd_wr_n            <= !(cs_act && nxt_write);
            end else begin
                byte_lane_strobe_n <= (strb_act && nxt_write) ? ~nxt_be : 2'b11;
                rd_wr_n            <= !(cs_act && nxt_write);
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            ext_addr     <= '0;
            ext_data_out <= '0;
        end else if (accept) begin
            ext_addr     <= acc_addr;
            ext_data_out <= acc_wdata;
        end
    end
    // read data taken as the strobe ends; the strobe frames it, no synchroniser
    always_ff @(posedge mclk) begin
        if (srst) begin
            acc_busy  <= 1'b0;
            acc_done  <= 1'b0;
            acc_rdata <= '0;
        end else begin
            acc_busy <= cs_act;
            acc_done <= (state_ff == ST_HOLD) && (nxt_state == ST_IDLE);
            if (strobe_ff && !strb_act && !write_ff) begin
                acc_rdata <= ext_data_in;
            end
        end
    end
    // helpers: cycles select was low before the strobe, during it up to any external wait, and after it
    logic [5:0] pre_run_ff, post_run_ff, strb_run_ff;
    always_ff @(posedge mclk) begin
        if (srst || state_ff == ST_IDLE) begin
            pre_run_ff  <= 6'h00;
            post_run_ff <= 6'h00;
            strb_run_ff <= 6'h00;
        end else begin
            if (state_ff == ST_SETUP) pre_run_ff <= pre_run_ff + 6'h01;
            if (state_ff == ST_HOLD) post_run_ff <= post_run_ff + 6'h01;
            if (state_ff == ST_STROBE) strb_run_ff <= strb_run_ff + 6'h01;
        end
    end

    a_wait_code7: assert property (@(posedge mclk) disable iff (srst)
        (nxt_wcode == 4'h7) |-> (wait_cyc == 5'h08))
        else $error("wait code 0111 not decoded as 8 cycles");
    a_strobe_len: assert property (@(posedge mclk) disable iff (srst)
        (state_ff == ST_STROBE && nxt_state != ST_STROBE)
        |-> (strb_run_ff + 6'h01 == 6'((int'(wait_cyc) + 1) * 2)))
        else $error("strobe length does not match wait code");
    a_wait_masked: assert property (@(posedge mclk) disable iff (srst)
        (state_ff == ST_STROBE && cnt_ff == 6'h00 && wm_ff) |=> (state_ff == ST_HOLD))
        else $error("masked external wait still extended access");
    a_wait_zero: assert property (@(posedge mclk) disable iff (srst)
        (state_ff == ST_STROBE && cnt_ff == 6'h00 && !wm_ff && wait_act_ff)
        |=> (state_ff == ST_EXTWAIT && strobe_ff))
        else $error("honoured external wait did not extend access");
    a_hold_len: assert property (@(posedge mclk) disable iff (srst)
        (state_ff == ST_HOLD && nxt_state == ST_IDLE)
        |-> (post_run_ff + 6'h01 == 6'({hold_ff, 1'b1})) ##1 (chip_select_n == 2'b11))
        else $error("hold after strobe has wrong length");
    a_setup_len: assert property (@(posedge mclk) disable iff (srst)
        $rose(strobe_ff) |-> ($past(pre_run_ff) + 6'h01 == 6'({setup_ff, 1'b1})))
        else $error("setup before strobe has wrong length");
    a_bas0_status: assert property (@(posedge mclk) disable iff (srst)
        (state_ff != ST_IDLE && bsram_ff && !bas_ff && write_ff) |-> !rd_wr_n)
        else $error("direction not held during byte sram write");
    a_bas1_status: assert property (@(posedge mclk) disable iff (srst)
        (state_ff != ST_IDLE && bsram_ff && bas_ff) |-> (byte_lane_strobe_n == ~be_ff))
        else $error("lane strobe not held during byte sram access");
    a_rsvd_zero: assert property (@(posedge mclk) disable iff (srst)
        ((area5_ff & ~AREA5_MASK) == 32'h0) && ((area6_ff & ~AREA6_MASK) == 32'h0))
        else $error("reserved register bits not zero");
    a_reset_wait: assert property (@(posedge mclk) disable iff (srst)
        $past(srst) |-> (area5_ff[POS_WAIT +: 4] == 4'hA && area6_ff[POS_WAIT +: 4] == 4'hA))
        else $error("wait field not 1010 after reset");
endmodule : sawt_sram_area_wait_timing
`default_nettype wire

// *** verif/sawt_sram_model.sv ***
`default_nettype none
module sawt_sram_model
    import sawt_pkg::*;
(
    input  wire logic              mclk,
    input  wire logic [1:0]        chip_select_n,
    input  wire logic [ADDR_W-1:0] ext_addr,
    input  wire logic [1:0]        byte_lane_strobe_n,
    input  wire logic              rd_wr_n,
    input  wire logic [DATA_W-1:0] ext_data_out,
    input  wire logic              ext_data_oe,
    input  wire logic [7:0]        stall,
    output logic      [DATA_W-1:0] ext_data_in,
    output logic                   ext_wait_n
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [DATA_W-1:0] mem [16];
    logic [7:0]        since_sel = 8'h00;
    logic              sel;
    assign sel = ~&chip_select_n;
    initial ext_data_in = 16'h5A5A;
    // a released bus toggles every cycle so stale data never passes for a read
    always @(posedge mclk) begin
        ext_data_in <= (sel && !ext_data_oe) ? mem[ext_addr[3:0]] : ~ext_data_in;
        since_sel <= sel ? since_sel + 8'h01 : 8'h00;
        for (int i = 0; i < 2; i++) begin
            if (sel && ext_data_oe && !rd_wr_n && !byte_lane_strobe_n[i]) begin
                mem[ext_addr[3:0]][8*i+:8] <= ext_data_out[8*i+:8];
            end
        end
    end
    // not ready for the first stall cycles of an access, already low when idle if stall is nonzero
    assign ext_wait_n = !(since_sel < stall);
endmodule : sawt_sram_model
`default_nettype wire

// *** verif/testbench.sv ***
`default_nettype none
module testbench
    import sawt_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic              mclk = 1'b0;
    logic              srst = 1'b1;
    logic              hsel = 1'b0;
    logic              hwrite = 1'b0;
    logic [31:0]       haddr = 32'h0000_0000;
    logic [31:0]       hwdata = 32'h0000_0000;
    logic [1:0]        htrans = 2'b00;
    logic [2:0]        hsize = 3'b010;
    logic [31:0]       hrdata, rd, v;
    logic              hreadyout, hresp, acc_busy, acc_done, rd_n, rd_wr_n, ext_data_oe;
    logic              ext_wait_n, bm;
    logic              acc_req = 1'b0;
    logic              acc_area6 = 1'b0;
    logic              acc_write = 1'b0;
    logic [ADDR_W-1:0] acc_addr = 20'h0_0000;
    logic [ADDR_W-1:0] ext_addr;
    logic [DATA_W-1:0] acc_wdata = 16'h0000;
    logic [DATA_W-1:0] acc_rdata, ext_data_out, ext_data_in, dat;
    logic [1:0]        acc_be = 2'b11;
    logic [1:0]        chip_select_n, byte_lane_strobe_n;
    logic [7:0]        stall = 8'h00;
    logic [12:0]       r;
    // {area6, write, wait code, mask, setup, hold, byte sram, byte select}
    logic [12:0]       rows [12] = '{13'h0840, 13'h00C4, 13'h1958, 13'h11EC, 13'h1A32,
        13'h1286, 13'h1B5B, 13'h13EF, 13'h0C08, 13'h048C, 13'h1D74, 13'h1590};
    int                miscompares = 0;
    int                samples_checked = 0;
    int                cyc = 0;
    int                n_st, n_stat, gap, hold, w, s, h;

    sawt_sram_area_wait_timing dut (
        .mclk, .srst, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout),
        .hrdata, .hreadyout, .hresp, .acc_req, .acc_area6, .acc_write, .acc_addr, .acc_wdata,
        .acc_be, .acc_busy, .acc_done, .acc_rdata, .ext_addr, .chip_select_n, .rd_n,
        .byte_lane_strobe_n, .rd_wr_n, .ext_data_out, .ext_data_oe, .ext_data_in, .ext_wait_n
    );
    sawt_sram_model far (
        .mclk, .chip_select_n, .ext_addr, .byte_lane_strobe_n, .rd_wr_n, .ext_data_out,
        .ext_data_oe, .stall, .ext_data_in, .ext_wait_n
    );

    always #12.5 mclk = ~mclk;

    task automatic stop_test();
        $display("checked %0d, mismatched %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : stop_test

    // the whole run needs about 500 cycles
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (cyc == 6000) begin
            miscompares++;
            stop_test();
        end
    end

    task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            miscompares++;
            $display("mismatch at %0t: value %h, expected %h", $time, got, exp);
        end
    endtask : chk_val

    task automatic chk_cnt(input int got, input int exp);
        samples_checked++;
        if (got != exp) begin
            miscompares++;
            $display("mismatch at %0t: count %0d, expected %0d", $time, got, exp);
        end
    endtask : chk_cnt

    task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] wd);
        @(posedge mclk);
        hsel <= 1'b1;
        htrans <= 2'b10;
        hwrite <= wr;
        haddr <= a;
        @(posedge mclk);
        while (hreadyout !== 1'b1) @(posedge mclk);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= wd;
        @(posedge mclk);
        while (hreadyout !== 1'b1) @(posedge mclk);
        rd = hrdata;
    endtask : ahb

    task automatic rreg(input logic [31:0] a, input logic [31:0] exp);
        ahb(1'b0, a, 32'h0000_0000);
        chk_val(rd, exp);
        chk_val({31'h0000_0000, hresp}, 32'h0000_0000);
    endtask : rreg

    // counts strobe, status, set-up and hold cycles while the select is low
    task automatic access(input logic a6, input logic wr, input logic [ADDR_W-1:0] ad,
                          input logic [DATA_W-1:0] wd, input logic bsel);
        logic st;
        logic sv;
        logic seen;
        @(posedge mclk);
        acc_req <= 1'b1;
        acc_area6 <= a6;
        acc_write <= wr;
        acc_addr <= ad;
        acc_wdata <= wd;
        @(posedge mclk);
        acc_req <= 1'b0;
        #1;
        n_st = 0;
        n_stat = 0;
        gap = 0;
        hold = 0;
        seen = 1'b0;
        for (int k = 0; k < 300 && acc_done !== 1'b1; k++) begin
            st = wr ? (bsel ? rd_wr_n : byte_lane_strobe_n[0]) : rd_n;
            sv = bsel ? byte_lane_strobe_n[0] : rd_wr_n;
            if (chip_select_n[a6] === 1'b0) begin
                n_stat += int'(sv === 1'b0);
                n_st += int'(st === 1'b0);
                gap += int'(!seen && st !== 1'b0);
                hold += int'(seen && st !== 1'b0);
                seen |= (st === 1'b0);
            end
            @(posedge mclk);
            #1;
        end
    endtask : access

    function automatic int wcyc(input logic [3:0] c);
        return c < 7 ? int'(c) : (c < 11 ? 2 * int'(c) - 6 : 18);
    endfunction : wcyc

    initial begin
        repeat (3) @(posedge mclk);
        srst <= 1'b0;
        for (int i = 0; i < 12; i++) begin
            r = rows[i];
            // reserved bits always written as zero
            v = r[12] ? {11'h000, r[0], 7'h00, r[5:4], r[10:6], 4'h0, r[3:2]}
                      : {21'h00_0000, r[10:6], 4'h0, r[3:2]};
            ahb(1'b1, r[12] ? 32'h0000_0004 : 32'h0000_0000, v);
            rreg(r[12] ? 32'h0000_0004 : 32'h0000_0000, v);
            ahb(1'b1, 32'h0000_0008, {31'h0000_0000, r[1]});
            bm = r[12] & r[1] & r[0];
            dat = 16'hC000 + 16'(i / 2) * 16'h0111;
            access(r[12], r[11], 20'(i / 2), dat, bm);
            w = 2 * (wcyc(r[10:7]) + 1);
            s = r[12] ? 2 * int'(r[5:4]) + 1 : 1;
            h = 2 * int'(r[3:2]) + 1;
            chk_cnt(n_st, w);
            chk_cnt(gap, s);
            chk_cnt(hold, h);
            chk_val({31'h0000_0000, acc_busy}, 32'h0000_0000);
            if (r[11]) begin
                chk_cnt(n_stat, s + w + h);
            end else begin
                chk_val({16'h0000, acc_rdata}, {16'h0000, dat});
            end
            $display("row %0d done", i);
        end
        // second reset in mid-run must restore the defaults
        @(posedge mclk);
        srst <= 1'b1;
        repeat (3) @(posedge mclk);
        srst <= 1'b0;
        rreg(32'h0000_0000, 32'h0000_0500);
        rreg(32'h0000_0004, 32'h0000_0500);
        rreg(32'h0000_0010, 32'h0000_0000);
        rreg(32'h0000_000C, 32'h0000_0000);
        access(1'b0, 1'b0, 20'h0_0001, 16'h0000, 1'b0);
        chk_cnt(n_st, 30);
        $display("reset test done");
        ahb(1'b1, 32'h0000_0000, 32'h0000_0000);
        stall <= 8'h0C;
        access(1'b0, 1'b1, 20'h0_0002, 16'h1234, 1'b0);
        chk_cnt(int'(n_st > 6), 1);
        ahb(1'b1, 32'h0000_0000, 32'h0000_0040);
        access(1'b0, 1'b1, 20'h0_0002, 16'h1234, 1'b0);
        chk_cnt(n_st, 2);
        $display("wait test done");
        stop_test();
    end
endmodule : testbench
`default_nettype wire
